// *** inc/boost_seq_regs.svh ***
// timing and encoding constants for the boost start-up and fault sequencer
`ifndef BOOST_SEQ_REGS_SVH
`define BOOST_SEQ_REGS_SVH

`define CLK_HZ              50000000
`define OSC_HZ              1000000
// one tick of the internal 1 MHz oscillator in 50 MHz cycles
`define OSC_DIV             (`CLK_HZ / `OSC_HZ)
`define OSC_DIV_W           6
// state durations in microseconds
`define T_INRUSH_US         2048
`define T_SWEN_US           128
`define T_SOFT_US           2048
// durations in oscillator ticks (1 us each)
`define TICKS_INRUSH        ((`T_INRUSH_US * `OSC_HZ) / 1000000)
`define TICKS_SWEN          ((`T_SWEN_US * `OSC_HZ) / 1000000)
`define TICKS_SOFT          ((`T_SOFT_US * `OSC_HZ) / 1000000)
`define TMR_W               12
// sync detector: edges must come closer than 1/300 kHz, 166 cycles at 50 MHz
`define SYNC_MIN_HZ         300000
`define SYNC_GAP_CYC        (`CLK_HZ / `SYNC_MIN_HZ)
`define SYNC_CNT_W          8
// minimum off-time of the switch node in cycles
`define TOFF_MIN_CYC        5
// current limit codes, percent of final value
`define ILIM_0              7'h00
`define ILIM_25             7'h19
`define ILIM_50             7'h32
`define ILIM_75             7'h4B
`define ILIM_100            7'h64

`endif

// *** inc/boost_seq_pkg.sv ***
// types for the boost start-up and fault sequencer
package boost_seq_pkg;
    typedef enum logic [6:0] {
        ST_OFF     = 7'h01,
        ST_INRUSH  = 7'h02,
        ST_SWEN    = 7'h04,
        ST_SB25    = 7'h08,
        ST_SB50    = 7'h10,
        ST_SB75    = 7'h20,
        ST_NORMAL  = 7'h40
    } seq_state_t;
endpackage

// *** hw/boost_startup_fault_sequencer.sv ***
// start-up sequencer, fault control, pwm timing and sync detect of a boost regulator
// What this block does
// - enable pin high shuts everything and outputs down, except feedback select and sync detect
// - enable pin high keeps supply disconnect switch open
// - enable low or restart launches six-state sequence
// - stay in normal until disable or fault
// - soft inrush 2.048ms, supply switch current source
// - supply enable 128us, supply switch fully on
// - three soft boost states step limit 25/50/75
// - normal after 8.32ms, current limit 100 percent
// - fault control can restart or stop any state
// - undervoltage disables outputs, waits for on threshold
// - overcurrent switches off and restarts at once
// - overvoltage holds off until recovery, then restarts
// - overtemperature holds off until cool, then restarts
// - skip pulses while output above target
// - every period keeps a minimum off-time
// - level select swaps feedback input and ground pins
// - external sync only above about 300kHz
// - synced switch-node falling edge follows sync falling edge
// - otherwise switching from internal 1MHz oscillator
`timescale 1ns/10ps
`default_nettype none
`include "boost_seq_regs.svh"

module boost_startup_fault_sequencer
    import boost_seq_pkg::*;
(
    input  wire logic       i_mclk,
    input  wire logic       i_rst_b,
    input  wire logic       i_active_low_enable_pin,
    input  wire logic       i_level_select,
    input  wire logic       i_external_sync_clock_in,
    input  wire logic       i_uv_below_off,
    input  wire logic       i_uv_above_on,
    input  wire logic       i_oc_switched_supply_node,
    input  wire logic       i_ov_boost_output_err,
    input  wire logic       i_ov_boost_output_recovered,
    input  wire logic       i_ot_above_off,
    input  wire logic       i_ot_below_on,
    input  wire logic       i_fb_above_target,
    input  wire logic       i_peak_current_reached,
    output logic            o_io_enable,
    output logic            o_supply_switch_current_src,
    output logic            o_supply_switch_full_on,
    output logic            o_switch_node_drive,
    output logic [6:0]      o_switch_node_ilim_pct,
    output logic            o_feedback_pin_a_gnd_en,
    output logic            o_feedback_pin_b_gnd_en,
    output logic            o_feedback_sel_b,
    output logic            o_ext_sync_active,
    output logic [6:0]      o_seq_state
);

    // pin and comparator synchronisers
    // the enable and sync stages reset to the pins' idle high level, so reset
    // is followed by neither a false start nor a false sync edge
    logic [1:0] en_s_q;
    logic [1:0] sel_s_q;
    logic [1:0] sync_s_q;
    logic [1:0] uvoff_s_q;
    logic [1:0] uvon_s_q;
    logic [1:0] oc_s_q;
    logic [1:0] ov_s_q;
    logic [1:0] ovr_s_q;
    logic [1:0] ot_s_q;
    logic [1:0] otr_s_q;
    logic [1:0] fb_s_q;
    logic [1:0] pk_s_q;

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            en_s_q    <= 2'h3;
            sel_s_q   <= 2'h0;
            sync_s_q  <= 2'h3;
            uvoff_s_q <= 2'h3;
            uvon_s_q  <= 2'h0;
            oc_s_q    <= 2'h0;
            ov_s_q    <= 2'h0;
            ovr_s_q   <= 2'h0;
            ot_s_q    <= 2'h0;
            otr_s_q   <= 2'h0;
            fb_s_q    <= 2'h0;
            pk_s_q    <= 2'h0;
        end else begin
            en_s_q    <= {en_s_q[0], i_active_low_enable_pin};
            sel_s_q   <= {sel_s_q[0], i_level_select};
            sync_s_q  <= {sync_s_q[0], i_external_sync_clock_in};
            uvoff_s_q <= {uvoff_s_q[0], i_uv_below_off};
            uvon_s_q  <= {uvon_s_q[0], i_uv_above_on};
            oc_s_q    <= {oc_s_q[0], i_oc_switched_supply_node};
            ov_s_q    <= {ov_s_q[0], i_ov_boost_output_err};
            ovr_s_q   <= {ovr_s_q[0], i_ov_boost_output_recovered};
            ot_s_q    <= {ot_s_q[0], i_ot_above_off};
            otr_s_q   <= {otr_s_q[0], i_ot_below_on};
            fb_s_q    <= {fb_s_q[0], i_fb_above_target};
            pk_s_q    <= {pk_s_q[0], i_peak_current_reached};
        end
    end

    logic disabled;
    assign disabled = en_s_q[1];

    // hold-off latches: a fault that waits for a recovery threshold keeps the
    // sequencer parked until the matching comparator reports recovery
    logic uv_hold_q;
    logic ov_hold_q;
    logic ot_hold_q;
    logic hold_any;
    logic oc_restart;

    // reset leaves the supply hold set: the supply must be seen good once
    // before the first start
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            uv_hold_q <= 1'b1;
        end else if (uvoff_s_q[1]) begin
            uv_hold_q <= 1'b1;
        end else if (uvon_s_q[1]) begin
            uv_hold_q <= 1'b0;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ov_hold_q <= 1'b0;
        end else if (disabled) begin
            ov_hold_q <= 1'b0;
        end else if (ov_s_q[1]) begin
            ov_hold_q <= 1'b1;
        end else if (ovr_s_q[1]) begin
            ov_hold_q <= 1'b0;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ot_hold_q <= 1'b0;
        end else if (disabled) begin
            ot_hold_q <= 1'b0;
        end else if (ot_s_q[1]) begin
            ot_hold_q <= 1'b1;
        end else if (otr_s_q[1]) begin
            ot_hold_q <= 1'b0;
        end
    end

    // the raw synchronised levels join the latches so the first fault cycle
    // already parks the sequencer
    assign hold_any   = uv_hold_q | ov_hold_q | ot_hold_q | uvoff_s_q[1] | ov_s_q[1] | ot_s_q[1];
    assign oc_restart = oc_s_q[1];

    // internal 1 MHz oscillator as a tick enable
    // a tick enable rather than a second clock keeps the block in one domain
    logic [`OSC_DIV_W-1:0] osc_cnt_q;
    logic                  osc_tick;

    assign osc_tick = (osc_cnt_q == `OSC_DIV_W'(`OSC_DIV - 1));

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            osc_cnt_q <= '0;
        end else if (osc_tick) begin
            osc_cnt_q <= '0;
        end else begin
            osc_cnt_q <= osc_cnt_q + `OSC_DIV_W'(1);
        end
    end

    // sequencer
    seq_state_t          state_q;
    seq_state_t          state_d;
    logic [`TMR_W-1:0]   tmr_q;
    logic [`TMR_W-1:0]   dur;
    logic                tmr_done;

    always_comb begin
        case (state_q)
            ST_INRUSH: dur = `TMR_W'(`TICKS_INRUSH);
            ST_SWEN:   dur = `TMR_W'(`TICKS_SWEN);
            ST_SB25:   dur = `TMR_W'(`TICKS_SOFT);
            ST_SB50:   dur = `TMR_W'(`TICKS_SOFT);
            ST_SB75:   dur = `TMR_W'(`TICKS_SOFT);
            default:   dur = '0;
        endcase
    end

    // the last tick of a state is duration-1 so the state lasts exactly its ticks
    assign tmr_done = osc_tick && (tmr_q == dur - `TMR_W'(1));

    always_comb begin
        state_d = state_q;
        if (disabled || hold_any || oc_restart) begin
            // a fault beats any timed advance in the same cycle
            state_d = ST_OFF;
        end else begin
            case (state_q)
                ST_OFF:    state_d = ST_INRUSH;
                ST_INRUSH: if (tmr_done) state_d = ST_SWEN;
                ST_SWEN:   if (tmr_done) state_d = ST_SB25;
                ST_SB25:   if (tmr_done) state_d = ST_SB50;
                ST_SB50:   if (tmr_done) state_d = ST_SB75;
                ST_SB75:   if (tmr_done) state_d = ST_NORMAL;
                ST_NORMAL: state_d = ST_NORMAL;
                default:   state_d = ST_OFF;
            endcase
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_q <= ST_OFF;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tmr_q <= '0;
        end else if (state_d != state_q) begin
            tmr_q <= '0;
        end else if (osc_tick) begin
            tmr_q <= tmr_q + `TMR_W'(1);
        end
    end

    // external sync detector: any gap longer than the 300 kHz period drops it
    logic [`SYNC_CNT_W-1:0] gap_q;
    logic                   sync_prev_q;
    logic                   sync_fall;
    logic                   ext_q;

    assign sync_fall = sync_prev_q & ~sync_s_q[1];

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sync_prev_q <= 1'b1;
        end else begin
            sync_prev_q <= sync_s_q[1];
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            gap_q <= '0;
            ext_q <= 1'b0;
        end else if (sync_fall) begin
            gap_q <= '0;
            ext_q <= 1'b1;
        end else if (gap_q == `SYNC_CNT_W'(`SYNC_GAP_CYC)) begin
            ext_q <= 1'b0;
        end else begin
            gap_q <= gap_q + `SYNC_CNT_W'(1);
        end
    end

    // pwm: period starts on the sync falling edge or the oscillator tick;
    // the switch turns on at period start and off at peak current, and the
    // last cycles of each period are forced off
    logic                 switching;
    logic                 period_start;
    logic [`OSC_DIV_W:0]  per_cnt_q;
    logic [`OSC_DIV_W:0]  per_len_q;
    logic                 in_toff;
    logic                 drive_q;

    assign switching    = (state_q == ST_SB25) || (state_q == ST_SB50) ||
                          (state_q == ST_SB75) || (state_q == ST_NORMAL);
    assign period_start = ext_q ? sync_fall : osc_tick;

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            per_cnt_q <= '0;
            per_len_q <= (`OSC_DIV_W+1)'(`OSC_DIV);
        end else if (period_start) begin
            per_cnt_q <= '0;
            per_len_q <= per_cnt_q + (`OSC_DIV_W+1)'(1);
        end else if (per_cnt_q != '1) begin
            per_cnt_q <= per_cnt_q + (`OSC_DIV_W+1)'(1);
        end
    end

    // one spare bit keeps a saturated period count from wrapping into a false on-window
    logic [`OSC_DIV_W+1:0] toff_reach;

    assign toff_reach = {1'b0, per_cnt_q} + (`OSC_DIV_W+2)'(`TOFF_MIN_CYC + 1);
    // off window is judged against the previous period length, so it
    // tracks whichever frequency is active
    assign in_toff    = toff_reach >= {1'b0, per_len_q};

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            drive_q <= 1'b0;
        end else if (!switching || fb_s_q[1]) begin
            drive_q <= 1'b0;
        end else if (period_start) begin
            drive_q <= 1'b1;
        end else if (in_toff || pk_s_q[1]) begin
            drive_q <= 1'b0;
        end
    end

    // outputs
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_io_enable                 <= 1'b0;
            o_supply_switch_current_src <= 1'b0;
            o_supply_switch_full_on     <= 1'b0;
            o_switch_node_ilim_pct      <= `ILIM_0;
            o_feedback_pin_a_gnd_en     <= 1'b0;
            o_feedback_pin_b_gnd_en     <= 1'b0;
            o_feedback_sel_b            <= 1'b0;
        end else begin
            o_io_enable                 <= !disabled && !uv_hold_q
                                           && !uvoff_s_q[1];
            o_supply_switch_current_src <= (state_d == ST_INRUSH);
            o_supply_switch_full_on     <= (state_d != ST_OFF)
                                           && (state_d != ST_INRUSH);
            case (state_d)
                ST_SB25:   o_switch_node_ilim_pct <= `ILIM_25;
                ST_SB50:   o_switch_node_ilim_pct <= `ILIM_50;
                ST_SB75:   o_switch_node_ilim_pct <= `ILIM_75;
                ST_NORMAL: o_switch_node_ilim_pct <= `ILIM_100;
                default:   o_switch_node_ilim_pct <= `ILIM_0;
            endcase
            o_feedback_pin_a_gnd_en     <= !disabled && sel_s_q[1];
            o_feedback_pin_b_gnd_en     <= !disabled && !sel_s_q[1];
            o_feedback_sel_b            <= sel_s_q[1];
        end
    end

    // the gate drops in the cycle a state change is decided, so a fault cuts
    // the switch in that cycle only; the registered drive stage drops it two cycles later
    assign o_switch_node_drive = drive_q && (state_q == state_d);
    assign o_ext_sync_active   = ext_q;
    assign o_seq_state         = state_q;

endmodule
`default_nettype wire

// *** testbench/boost_seq_asserts.sv ***
// concurrent checks on the boost sequencer ports
`timescale 1ns/10ps
`default_nettype none
`include "boost_seq_regs.svh"
module boost_seq_asserts
    import boost_seq_pkg::*;
(
    input wire logic       i_mclk,
    input wire logic       i_rst_b,
    input wire logic       i_active_low_enable_pin,
    input wire logic       i_level_select,
    input wire logic       i_oc_switched_supply_node,
    input wire logic       i_ov_boost_output_err,
    input wire logic       i_ot_above_off,
    input wire logic       o_io_enable,
    input wire logic       o_supply_switch_current_src,
    input wire logic       o_supply_switch_full_on,
    input wire logic       o_switch_node_drive,
    input wire logic [6:0] o_switch_node_ilim_pct,
    input wire logic       o_feedback_pin_a_gnd_en,
    input wire logic       o_feedback_pin_b_gnd_en,
    input wire logic       o_feedback_sel_b,
    input wire logic [6:0] o_seq_state
);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_b);
    // five cycles cover the two sync stages, the state register and the output register
    a_disable_quiet: assert property (
        i_active_low_enable_pin [*5] |-> !o_io_enable && !o_supply_switch_full_on
        && !o_switch_node_drive && o_seq_state == ST_OFF) else $error("active while disabled");
    a_seq_order: assert property (
        o_seq_state != $past(o_seq_state) |-> o_seq_state == ST_OFF
        || o_seq_state == ($past(o_seq_state) << 1)) else $error("illegal state step");
    a_inrush_src: assert property (
        (o_seq_state == ST_INRUSH) [*2] |-> o_supply_switch_current_src
        && !o_supply_switch_full_on) else $error("inrush switch mode wrong");
    a_swen_full: assert property (
        (o_seq_state == ST_SWEN) [*2] |-> o_supply_switch_full_on
        && !o_supply_switch_current_src && !o_switch_node_drive) else $error("supply enable wrong");
    a_ilim_first: assert property (
        (o_seq_state == ST_SB25) [*2] |-> o_switch_node_ilim_pct == `ILIM_25)
        else $error("first soft limit wrong");
    a_ilim_last: assert property (
        (o_seq_state == ST_SB75) [*2] |-> o_switch_node_ilim_pct == `ILIM_75)
        else $error("last soft limit wrong");
    a_ilim_full: assert property (
        (o_seq_state == ST_NORMAL) [*2] |-> o_switch_node_ilim_pct == `ILIM_100)
        else $error("normal limit wrong");
    a_oc_off: assert property (
        i_oc_switched_supply_node [*5] |-> o_seq_state == ST_OFF && !o_switch_node_drive
        && !o_supply_switch_full_on) else $error("overcurrent not stopped");
    a_hold_off: assert property (
        (i_ov_boost_output_err || i_ot_above_off) [*5] |-> o_seq_state == ST_OFF
        && !o_switch_node_drive && !o_supply_switch_full_on) else $error("hold fault not stopped");
    // the fall sample plus four more make the five low cycles of the minimum
    // off-time; a fall caused by the state-change gate is not a period end
    a_min_off: assert property (
        $fell(o_switch_node_drive) ##1 $stable(o_seq_state) |-> !o_switch_node_drive [*4])
        else $error("off-time too short");
    a_sel_swap: assert property (
        (o_io_enable && $stable(i_level_select)) [*5] |-> o_feedback_sel_b == i_level_select
        && o_feedback_pin_a_gnd_en == i_level_select && o_feedback_pin_b_gnd_en != i_level_select)
        else $error("feedback roles wrong");
endmodule
bind boost_startup_fault_sequencer boost_seq_asserts boost_seq_asserts_i (
    .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_active_low_enable_pin(i_active_low_enable_pin),
    .i_level_select(i_level_select), .i_oc_switched_supply_node(i_oc_switched_supply_node),
    .i_ov_boost_output_err(i_ov_boost_output_err), .i_ot_above_off(i_ot_above_off),
    .o_io_enable(o_io_enable), .o_supply_switch_current_src(o_supply_switch_current_src),
    .o_supply_switch_full_on(o_supply_switch_full_on), .o_switch_node_drive(o_switch_node_drive),
    .o_switch_node_ilim_pct(o_switch_node_ilim_pct),
    .o_feedback_pin_a_gnd_en(o_feedback_pin_a_gnd_en),
    .o_feedback_pin_b_gnd_en(o_feedback_pin_b_gnd_en), .o_feedback_sel_b(o_feedback_sel_b),
    .o_seq_state(o_seq_state));
`default_nettype wire

// *** testbench/boost_host_model.sv ***
// host side: clocks the sync pin or holds it high
`timescale 1ns/10ps
`default_nettype none
module boost_host_model #(
    parameter int HALF = 20
) (
    input  wire logic i_mclk,
    input  wire logic i_run,
    output logic      o_sync = 1'b1
);
    int cnt_q;
    // 20-cycle halves give 1.25 MHz, well inside the accepted external range
    always_ff @(posedge i_mclk) begin
        if (!i_run) begin
            cnt_q  <= 0;
            o_sync <= 1'b1;
        end else if (cnt_q == HALF - 1) begin
            cnt_q  <= 0;
            o_sync <= ~o_sync;
        end else begin
            cnt_q <= cnt_q + 1;
        end
    end
endmodule
`default_nettype wire

// *** testbench/test_boost_startup_fault_sequencer.sv ***
// self-checking bench for the boost start-up and fault sequencer
`timescale 1ns/10ps
`default_nettype none
`include "boost_seq_regs.svh"
module test_boost_startup_fault_sequencer
    import boost_seq_pkg::*;
;
    logic       i_mclk = 1'b0;
    logic       i_rst_b = 1'b0;
    logic       i_active_low_enable_pin = 1'b1;
    logic       i_level_select = 1'b0;
    logic       i_fb_above_target = 1'b0;
    logic       i_peak_current_reached = 1'b0;
    logic       run = 1'b0;
    logic       no_peak = 1'b0;
    logic [3:0] err = 4'h0;
    logic [3:0] rec = 4'hF;
    wire logic  i_external_sync_clock_in;
    logic       o_io_enable, o_supply_switch_current_src, o_supply_switch_full_on;
    logic       o_switch_node_drive, o_feedback_pin_a_gnd_en, o_feedback_pin_b_gnd_en;
    logic       o_feedback_sel_b, o_ext_sync_active, last;
    logic [6:0] o_switch_node_ilim_pct, o_seq_state;
    int         fails = 0;
    int         tests_run = 0;
    int         tot, pulses, hi_cyc;

    boost_startup_fault_sequencer boost_startup_fault_sequencer_i (
        .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_active_low_enable_pin(i_active_low_enable_pin),
        .i_level_select(i_level_select), .i_external_sync_clock_in(i_external_sync_clock_in),
        .i_uv_below_off(err[0]), .i_uv_above_on(rec[0]), .i_oc_switched_supply_node(err[1]),
        .i_ov_boost_output_err(err[2]), .i_ov_boost_output_recovered(rec[2]),
        .i_ot_above_off(err[3]), .i_ot_below_on(rec[3]), .i_fb_above_target(i_fb_above_target),
        .i_peak_current_reached(i_peak_current_reached), .o_io_enable(o_io_enable),
        .o_supply_switch_current_src(o_supply_switch_current_src),
        .o_supply_switch_full_on(o_supply_switch_full_on),
        .o_switch_node_drive(o_switch_node_drive), .o_switch_node_ilim_pct(o_switch_node_ilim_pct),
        .o_feedback_pin_a_gnd_en(o_feedback_pin_a_gnd_en),
        .o_feedback_pin_b_gnd_en(o_feedback_pin_b_gnd_en), .o_feedback_sel_b(o_feedback_sel_b),
        .o_ext_sync_active(o_ext_sync_active), .o_seq_state(o_seq_state));
    boost_host_model boost_host_model_i (.i_mclk(i_mclk), .i_run(run),
        .o_sync(i_external_sync_clock_in));

    always #10 i_mclk = ~i_mclk;
    // crude plant: the peak comparator trips right after the gate turns on
    always @(posedge i_mclk) i_peak_current_reached <= o_switch_node_drive && !no_peak;

    task chk(input string nm, input logic [6:0] e, input logic [6:0] g);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task rng(input string nm, input int lo, input int hi, input int v);
        tests_run++;
        if (v < lo || v > hi) begin
            fails++;
            $display("BAD %s exp %0d..%0d got %0d", nm, lo, hi, v);
        end
    endtask
    task step;
        @(negedge i_mclk);
        tot++;
        if (o_switch_node_drive === 1'b1 && last !== 1'b1) pulses++;
        if (o_switch_node_drive === 1'b1) hi_cyc++;
        last = o_switch_node_drive;
    endtask
    task rises(input int n);
        pulses = 0;
        repeat (n) step();
    endtask
    // waits for a state, then judges its arrival time and the pulses seen before it
    task go(input logic [6:0] st, input logic [6:0] il, input int lo, input int hi,
            input int pl, input int ph);
        int n;
        n = 0;
        pulses = 0;
        while (o_seq_state !== st && n < hi + 2) begin
            step();
            n++;
        end
        chk("state", st, o_seq_state);
        rng("time", lo, hi, n);
        rng("pulses", pl, ph, pulses);
        repeat (2) step();
        chk("ilim", il, o_switch_node_ilim_pct);
    endtask
    task t_off;
        chk("off outs", 7'h00, {o_io_enable, o_supply_switch_current_src,
            o_supply_switch_full_on, o_switch_node_drive, o_feedback_pin_a_gnd_en,
            o_feedback_pin_b_gnd_en});
        chk("off state", ST_OFF, o_seq_state);
    endtask
    task t_startup;
        @(posedge i_mclk) i_active_low_enable_pin <= 1'b0;
        tot = 0;
        go(ST_INRUSH, 7'h00, 1, 8, 0, 0);
        go(ST_SWEN, 7'h00, 102346, 102402, 0, 0);
        go(ST_SB25, 7'h19, 6396, 6402, 0, 0);
        go(ST_SB50, 7'h32, 102396, 102402, 2000, 2060);
        go(ST_SB75, 7'h4B, 102396, 102402, 2000, 2060);
        go(ST_NORMAL, 7'h64, 102396, 102402, 2000, 2060);
        rng("total", 408672, 416928, tot);
        repeat (200) step();
        chk("stay", ST_NORMAL, o_seq_state);
    endtask
    task t_select;
        @(posedge i_mclk) i_level_select <= 1'b1;
        repeat (6) step();
        chk("sel one", 7'h06, {o_feedback_sel_b, o_feedback_pin_a_gnd_en,
            o_feedback_pin_b_gnd_en});
        @(posedge i_mclk) i_level_select <= 1'b0;
        repeat (6) step();
        chk("sel zero", 7'h01, {o_feedback_sel_b, o_feedback_pin_a_gnd_en,
            o_feedback_pin_b_gnd_en});
    endtask
    task t_skip;
        @(posedge i_mclk) i_fb_above_target <= 1'b1;
        repeat (10) step();
        rises(300);
        rng("skip", 0, 0, pulses);
        @(posedge i_mclk) i_fb_above_target <= 1'b0;
        rises(300);
        rng("resume", 5, 7, pulses);
    endtask
    // with the peak comparator silent only the minimum off-time ends each pulse
    task t_maxduty;
        @(posedge i_mclk) no_peak <= 1'b1;
        repeat (60) step();
        hi_cyc = 0;
        rises(300);
        rng("max duty", 298 - (300 / `OSC_DIV) * `TOFF_MIN_CYC,
            302 - (300 / `OSC_DIV) * `TOFF_MIN_CYC, hi_cyc);
        @(posedge i_mclk) no_peak <= 1'b0;
        repeat (10) step();
    endtask
    task t_sync;
        @(posedge i_mclk) run <= 1'b1;
        repeat (400) step();
        chk("sync on", 7'h01, o_ext_sync_active);
        rises(1000);
        rng("sync rate", 24, 26, pulses);
        @(posedge i_mclk) run <= 1'b0;
        repeat (400) step();
        chk("sync off", 7'h00, o_ext_sync_active);
        rises(1000);
        rng("osc rate", 19, 21, pulses);
    endtask
    // bit order of err and rec: undervoltage, overcurrent, overvoltage, temperature
    task t_faults;
        for (int k = 0; k < 4; k++) begin
            @(posedge i_mclk) begin
                err[k] <= 1'b1;
                rec[k] <= 1'b0;
            end
            repeat (8) step();
            chk("fault state", ST_OFF, o_seq_state);
            chk("fault sw", 7'h00, {o_supply_switch_full_on,
                o_supply_switch_current_src, o_switch_node_drive});
            if (k == 0) chk("uv io", 7'h00, o_io_enable);
            @(posedge i_mclk) err[k] <= 1'b0;
            repeat (8) step();
            if (k != 1) chk("held", ST_OFF, o_seq_state);
            @(posedge i_mclk) rec[k] <= 1'b1;
            repeat (8) step();
            chk("restart", ST_INRUSH, o_seq_state);
        end
    endtask
    task final_report;
        $display("tests_run %0d fails %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge i_mclk);
        i_rst_b <= 1'b1;
        repeat (10) step();
        t_off();
        t_startup();
        t_select();
        t_skip();
        t_maxduty();
        t_sync();
        t_faults();
        @(posedge i_mclk) i_active_low_enable_pin <= 1'b1;
        repeat (6) step();
        t_off();
        final_report();
    end
    initial begin
        #20000000;
        fails++;
        final_report();
    end
endmodule
`default_nettype wire
